// [hw/pcc_pkg.sv]
// constants for the per-port congestion context block
package pcc_pkg;

  // ----------------------------------------------------------------
  // indirect access: memory select and quad-word addresses
  // ----------------------------------------------------------------
  localparam int QADDR_W = 11;
  localparam int LW_N = 4;
  localparam int LW_W = 34;
  localparam logic SEL_INTERNAL = 1'h1;
  localparam logic [QADDR_W-1:0] THR_LOOP_BASE = 11'h200;   // 512
  localparam logic [QADDR_W-1:0] THR_WAN_QADDR = 11'h611;   // 1553
  localparam logic [QADDR_W-1:0] CNT_LOOP_BASE = 11'h400;   // 1024
  localparam logic [QADDR_W-1:0] CNT_WAN_QADDR = 11'h612;   // 1554
  localparam logic [QADDR_W-1:0] UPORT_QADDR = 11'h613;     // 1555
  localparam logic [1:0] WAN_LW = 2'h0;
  localparam logic [1:0] UPORT_THR_LW = 2'h1;
  localparam logic [1:0] UPORT_CNT_LW = 2'h2;

  // ----------------------------------------------------------------
  // threshold record fields
  // ----------------------------------------------------------------
  localparam int THR_W = 16;
  localparam int THR_HI_MSB = 15;
  localparam int THR_HI_LSB = 8;
  localparam int THR_LO_MSB = 7;
  localparam int THR_LO_LSB = 0;

  // ----------------------------------------------------------------
  // count record fields
  // ----------------------------------------------------------------
  localparam int CNT_ACT_BIT = 31;
  localparam int CNT_MAX_MSB = 27;
  localparam int CNT_MAX_LSB = 20;
  localparam int CNT_Q_MSB = 17;
  localparam int CNT_Q_LSB = 0;
  localparam int CNT_W = 18;
  localparam int LOGF_W = 8;
  localparam int EXP_W = 20;
  localparam int CIRC_CNT_W = 13;
  localparam int CIRC_ID_W = 16;
  localparam int AMT_W = 14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [THR_W-1:0] THR_RESET = 16'h0000;
  localparam logic [LOGF_W-1:0] MAX_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 18'h00000;

endpackage

// [hw/pcc_port_context.sv]
// per-port congestion context: thresholds, port enable, queued-cell count
module pcc_port_context #(
  parameter int NUM_LOOP = 8,
  parameter int NUM_CLASS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic context_memory_select,
  input wire logic [pcc_pkg::QADDR_W-1:0] quad_word_address,
  input wire logic [pcc_pkg::LW_N-1:0] long_word_enable,
  input wire logic mp_wr,
  input wire logic mp_rd,
  input wire logic [pcc_pkg::LW_N*pcc_pkg::LW_W-1:0] mp_wdata,
  output logic [pcc_pkg::LW_N*pcc_pkg::LW_W-1:0] mp_rdata,
  output logic mp_rvalid,
  input wire logic arr_valid,
  input wire logic [$clog2(NUM_LOOP+2)-1:0] arr_port,
  input wire logic [pcc_pkg::CIRC_ID_W-1:0] arr_circuit,
  input wire logic arr_low_priority,
  input wire logic arr_min_met,
  input wire logic arr_frame_continuous_queueing,
  input wire logic arr_packet_mode,
  input wire logic arr_first_cell,
  input wire logic arr_reasm_active,
  input wire logic [pcc_pkg::CIRC_CNT_W-1:0] arr_reasm_len,
  output logic arr_accept,
  output logic arr_drop,
  output logic arr_congestion_drop,
  output logic dropped_cell_total_inc,
  output logic priority_drop_total_inc,
  output logic [pcc_pkg::AMT_W-1:0] priority_drop_amount,
  output logic rx_error_irq,
  output logic [pcc_pkg::CIRC_ID_W-1:0] rx_error_circuit_id,
  input wire logic deq_valid,
  input wire logic [$clog2(NUM_LOOP+2)-1:0] deq_port,
  input wire logic td_valid,
  input wire logic td_is_class,
  input wire logic [$clog2(NUM_LOOP+2)-1:0] td_port,
  input wire logic [pcc_pkg::CNT_W-1:0] td_cells,
  input wire logic tx_valid,
  input wire logic [$clog2(NUM_LOOP+2)-1:0] tx_port,
  input wire logic [$clog2(NUM_CLASS)-1:0] tx_class,
  input wire logic tx_shaped,
  input wire logic [pcc_pkg::CIRC_CNT_W-1:0] tx_circuit_cells,
  output logic tx_grant,
  output logic tx_answer,
  output logic [NUM_LOOP+1:0] port_active
);

  // ----------------------------------------------------------------
  // sizes and state
  // ----------------------------------------------------------------
  localparam int NP = NUM_LOOP + 2;
  localparam int PW = $clog2(NP);
  localparam int WAN_P = NUM_LOOP;
  localparam int UP_P = NUM_LOOP + 1;
  localparam int NQ = (NUM_LOOP + 3) / 4;
  localparam int DW = pcc_pkg::LW_N * pcc_pkg::LW_W;

  typedef struct packed {
    logic [NP-1:0][pcc_pkg::THR_W-1:0] thr;
    logic [NP-1:0] act;
    logic [NP-1:0][pcc_pkg::LOGF_W-1:0] maxt;
    logic [NP-1:0][pcc_pkg::CNT_W-1:0] cnt;
    logic [NP-1:0][NUM_CLASS-1:0] head_sent;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic accept;
    logic drop;
    logic cong;
    logic disc_inc;
    logic prio_inc;
    logic [pcc_pkg::AMT_W-1:0] amt;
    logic irq;
    logic [pcc_pkg::CIRC_ID_W-1:0] err_id;
    logic grant;
    logic answer;
  } pcc_state_t;

  pcc_state_t st_q;
  pcc_state_t st_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // log/fraction code to cell count; widened so 2^15*31/16 cannot wrap
  function automatic logic [pcc_pkg::EXP_W-1:0] expand(input logic [pcc_pkg::LOGF_W-1:0] code);
    logic [pcc_pkg::EXP_W-1:0] mant;
    begin
      mant = {15'h0000, 1'b1, code[3:0]};
      expand = pcc_pkg::EXP_W'((mant << code[7:4]) >> 4);
    end
  endfunction

  // quad address and lane to {hit, count-record, port}
  function automatic logic [PW+1:0] decode(input logic [pcc_pkg::QADDR_W-1:0] qa, input logic [1:0] lw);
    int p;
    logic hit;
    logic is_cnt;
    begin
      p = 0;
      hit = 1'b0;
      is_cnt = 1'b0;
      if (qa >= pcc_pkg::THR_LOOP_BASE && qa < pcc_pkg::THR_LOOP_BASE + NQ) begin
        p = int'(qa - pcc_pkg::THR_LOOP_BASE) * 4 + int'(lw);
        hit = (p < NUM_LOOP);
      end else if (qa >= pcc_pkg::CNT_LOOP_BASE && qa < pcc_pkg::CNT_LOOP_BASE + NQ) begin
        p = int'(qa - pcc_pkg::CNT_LOOP_BASE) * 4 + int'(lw);
        hit = (p < NUM_LOOP);
        is_cnt = 1'b1;
      end else if (qa == pcc_pkg::THR_WAN_QADDR && lw == pcc_pkg::WAN_LW) begin
        p = WAN_P;
        hit = 1'b1;
      end else if (qa == pcc_pkg::CNT_WAN_QADDR && lw == pcc_pkg::WAN_LW) begin
        p = WAN_P;
        hit = 1'b1;
        is_cnt = 1'b1;
      end else if (qa == pcc_pkg::UPORT_QADDR && lw == pcc_pkg::UPORT_THR_LW) begin
        p = UP_P;
        hit = 1'b1;
      end else if (qa == pcc_pkg::UPORT_QADDR && lw == pcc_pkg::UPORT_CNT_LW) begin
        p = UP_P;
        hit = 1'b1;
        is_cnt = 1'b1;
      end
      decode = {hit, is_cnt, PW'(p)};
    end
  endfunction

  // congestion test for the arriving cell against the port's ceilings
  logic arr_act;
  logic cong_now;
  logic [pcc_pkg::EXP_W-1:0] arr_cnt;
  logic [pcc_pkg::LOGF_W-1:0] prio_code;
  assign arr_act = st_q.act[arr_port];
  assign arr_cnt = {2'h0, st_q.cnt[arr_port]};
  assign prio_code = arr_low_priority ? st_q.thr[arr_port][pcc_pkg::THR_LO_MSB:pcc_pkg::THR_LO_LSB] :
                     st_q.thr[arr_port][pcc_pkg::THR_HI_MSB:pcc_pkg::THR_HI_LSB];
  // high-priority cells below their minimum only face the port ceiling
  assign cong_now = (st_q.maxt[arr_port] != '0 && arr_cnt >= expand(st_q.maxt[arr_port])) ||
                    ((arr_low_priority || arr_min_met) && prio_code != '0 && arr_cnt >= expand(prio_code));

  logic [PW+1:0] dec [pcc_pkg::LW_N];
  logic [pcc_pkg::LW_W-1:0] wlane [pcc_pkg::LW_N];
  logic [pcc_pkg::EXP_W-1:0] nxt [NP];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.accept = 1'b0;
    st_d.drop = 1'b0;
    st_d.cong = 1'b0;
    st_d.disc_inc = 1'b0;
    st_d.prio_inc = 1'b0;
    st_d.amt = '0;
    st_d.irq = 1'b0;
    st_d.grant = 1'b0;
    st_d.answer = 1'b0;
    for (int l = 0; l < pcc_pkg::LW_N; l++) begin
      dec[l] = decode(quad_word_address, 2'(l));
      wlane[l] = mp_wdata[l*pcc_pkg::LW_W +: pcc_pkg::LW_W];
    end
    // cell count: arrivals add, departures and teardowns subtract
    for (int p = 0; p < NP; p++) begin
      nxt[p] = {2'h0, st_q.cnt[p]};
    end
    if (arr_valid) begin
      if (!arr_act) begin
        st_d.drop = 1'b1;
        st_d.irq = 1'b1;
        st_d.err_id = arr_circuit;
        if (arr_frame_continuous_queueing) begin
          st_d.prio_inc = 1'b1;
          st_d.amt = arr_reasm_active ? {1'b0, arr_reasm_len} + 14'h0001 : 14'h0001;
        end else if (!arr_packet_mode || arr_first_cell) begin
          st_d.disc_inc = 1'b1;
        end else begin
          st_d.prio_inc = 1'b1;
          st_d.amt = 14'h0001;
        end
      end else if (cong_now) begin
        st_d.drop = 1'b1;
        st_d.cong = 1'b1;
      end else begin
        st_d.accept = 1'b1;
        nxt[arr_port] = nxt[arr_port] + 20'h00001;
      end
    end
    if (deq_valid && nxt[deq_port] != '0) begin
      nxt[deq_port] = nxt[deq_port] - 20'h00001;
    end
    // both-priority circuit total or class total, floored at zero
    if (td_valid) begin
      nxt[td_port] = (nxt[td_port] > {2'h0, td_cells}) ?
                     nxt[td_port] - {2'h0, td_cells} : '0;
    end
    for (int p = 0; p < NP; p++) begin
      st_d.cnt[p] = (nxt[p] > {2'h0, {pcc_pkg::CNT_W{1'b1}}}) ? {pcc_pkg::CNT_W{1'b1}} : nxt[p][pcc_pkg::CNT_W-1:0];
    end
    // transmit permission for a queued cell of this port and class
    if (tx_valid) begin
      st_d.answer = 1'b1;
      if (st_q.act[tx_port]) begin
        st_d.grant = 1'b1;
      end else if (tx_shaped) begin
        st_d.grant = (tx_circuit_cells > 13'h0001);
      end else if (!st_q.head_sent[tx_port][tx_class]) begin
        st_d.grant = 1'b1;
        st_d.head_sent[tx_port][tx_class] = 1'b1;
      end
    end
    // host write wins over same-cycle count updates; software masks live fields
    if (mp_wr && context_memory_select == pcc_pkg::SEL_INTERNAL) begin
      for (int l = 0; l < pcc_pkg::LW_N; l++) begin
        if (long_word_enable[l] && dec[l][PW+1]) begin
          if (dec[l][PW]) begin
            if (st_q.act[dec[l][PW-1:0]] && !wlane[l][pcc_pkg::CNT_ACT_BIT]) begin
              st_d.head_sent[dec[l][PW-1:0]] = '0;
            end
            st_d.act[dec[l][PW-1:0]] = wlane[l][pcc_pkg::CNT_ACT_BIT];
            st_d.maxt[dec[l][PW-1:0]] = wlane[l][pcc_pkg::CNT_MAX_MSB:pcc_pkg::CNT_MAX_LSB];
            st_d.cnt[dec[l][PW-1:0]] = wlane[l][pcc_pkg::CNT_Q_MSB:pcc_pkg::CNT_Q_LSB];
          end else begin
            st_d.thr[dec[l][PW-1:0]] = wlane[l][pcc_pkg::THR_W-1:0];
          end
        end
      end
    end
    // read returns every enabled lane; unmapped lanes read zero
    if (mp_rd) begin
      st_d.rvalid = 1'b1;
      for (int l = 0; l < pcc_pkg::LW_N; l++) begin
        st_d.rdata[l*pcc_pkg::LW_W +: pcc_pkg::LW_W] = '0;
        if (context_memory_select == pcc_pkg::SEL_INTERNAL && long_word_enable[l] && dec[l][PW+1]) begin
          if (dec[l][PW]) begin
            st_d.rdata[l*pcc_pkg::LW_W +: pcc_pkg::LW_W] = {2'h0, st_q.act[dec[l][PW-1:0]], 3'h0,
              st_q.maxt[dec[l][PW-1:0]], 2'h0, st_q.cnt[dec[l][PW-1:0]]};
          end else begin
            st_d.rdata[l*pcc_pkg::LW_W +: pcc_pkg::LW_W] = {18'h00000, st_q.thr[dec[l][PW-1:0]]};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign mp_rdata = st_q.rdata;
  assign mp_rvalid = st_q.rvalid;
  assign arr_accept = st_q.accept;
  assign arr_drop = st_q.drop;
  assign arr_congestion_drop = st_q.cong;
  assign dropped_cell_total_inc = st_q.disc_inc;
  assign priority_drop_total_inc = st_q.prio_inc;
  assign priority_drop_amount = st_q.amt;
  assign rx_error_irq = st_q.irq;
  assign rx_error_circuit_id = st_q.err_id;
  assign tx_grant = st_q.grant;
  assign tx_answer = st_q.answer;
  assign port_active = st_q.act;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic head_done;
  assign head_done = st_q.head_sent[tx_port][tx_class];

  property p_inactive_drop;
    @(posedge mclk) disable iff (!rst_n)
    arr_valid && !arr_act |=> arr_drop && rx_error_irq && !arr_accept && rx_error_circuit_id == $past(arr_circuit);
  endproperty
  a_inactive_drop: assert property (p_inactive_drop) else $error("inactive port cell not dropped");

  property p_cell_mode;
    @(posedge mclk) disable iff (!rst_n)
    arr_valid && !arr_act && !arr_frame_continuous_queueing && !arr_packet_mode
      |=> dropped_cell_total_inc && !priority_drop_total_inc;
  endproperty
  a_cell_mode: assert property (p_cell_mode) else $error("per-cell discard count wrong");

  property p_packet_mode;
    @(posedge mclk) disable iff (!rst_n)
    arr_valid && !arr_act && !arr_frame_continuous_queueing && arr_packet_mode
      |=> dropped_cell_total_inc == $past(arr_first_cell) && priority_drop_total_inc == !$past(arr_first_cell);
  endproperty
  a_packet_mode: assert property (p_packet_mode) else $error("packet discard counter choice wrong");

  property p_fcq_amount;
    @(posedge mclk) disable iff (!rst_n)
    arr_valid && !arr_act && arr_frame_continuous_queueing && arr_reasm_active
      |=> priority_drop_total_inc && priority_drop_amount == {1'b0, $past(arr_reasm_len)} + 14'h0001;
  endproperty
  a_fcq_amount: assert property (p_fcq_amount) else $error("reassembly discard amount wrong");

  property p_congestion;
    @(posedge mclk) disable iff (!rst_n)
    arr_valid && arr_act && cong_now |=> arr_congestion_drop && !arr_accept;
  endproperty
  a_congestion: assert property (p_congestion) else $error("congested cell accepted");

  property p_active_tx;
    @(posedge mclk) disable iff (!rst_n)
    tx_valid && st_q.act[tx_port] |=> tx_answer && tx_grant;
  endproperty
  a_active_tx: assert property (p_active_tx) else $error("active port transmit refused");

  property p_head_only;
    @(posedge mclk) disable iff (!rst_n)
    tx_valid && !st_q.act[tx_port] && !tx_shaped && head_done |=> tx_answer && !tx_grant;
  endproperty
  a_head_only: assert property (p_head_only) else $error("non-head cell sent on disabled port");

  property p_shaped_last;
    @(posedge mclk) disable iff (!rst_n)
    tx_valid && !st_q.act[tx_port] && tx_shaped |=> tx_grant == ($past(tx_circuit_cells) > 13'h0001);
  endproperty
  a_shaped_last: assert property (p_shaped_last) else $error("shaped drain limit broken");

  property p_uport_read;
    @(posedge mclk) disable iff (!rst_n)
    mp_rd && context_memory_select == pcc_pkg::SEL_INTERNAL && quad_word_address == pcc_pkg::UPORT_QADDR
      && long_word_enable[pcc_pkg::UPORT_THR_LW] && !mp_wr
      |=> mp_rvalid && mp_rdata[pcc_pkg::LW_W +: pcc_pkg::THR_W] == $past(st_q.thr[UP_P]);
  endproperty
  a_uport_read: assert property (p_uport_read) else $error("uP threshold read wrong");

endmodule

// [verif/pcc_host_model.sv]
// host model: indirect context record access by quad word address and lane
module pcc_host_model (
  input wire logic mclk,
  output logic context_memory_select,
  output logic [pcc_pkg::QADDR_W-1:0] quad_word_address,
  output logic [pcc_pkg::LW_N-1:0] long_word_enable,
  output logic mp_wr,
  output logic mp_rd,
  output logic [pcc_pkg::LW_N*pcc_pkg::LW_W-1:0] mp_wdata,
  input wire logic [pcc_pkg::LW_N*pcc_pkg::LW_W-1:0] mp_rdata,
  input wire logic mp_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // idle bus
  initial begin
    {context_memory_select, quad_word_address, long_word_enable, mp_wr, mp_rd, mp_wdata} = '0;
  end

  // one lane a write; the live count field takes the caller's value, nonzero for port 2 and the uP port at setup
  // address and data are inverted after the strobe so stale values never look valid
  task automatic wr(input logic [10:0] qa, input logic [1:0] ln, input logic sel, input logic [33:0] d);
    @(posedge mclk);
    context_memory_select <= sel;
    quad_word_address <= qa;
    long_word_enable <= 4'h1 << ln;
    mp_wdata <= 136'(d) << (34 * ln);
    mp_wr <= 1'h1;
    @(posedge mclk);
    mp_wr <= 1'h0;
    quad_word_address <= ~qa;
    mp_wdata <= ~mp_wdata;
  endtask

  // read strobe, answer settled just after the following edge
  task automatic rd(input logic [10:0] qa, input logic [1:0] ln, output logic [33:0] d, output logic v);
    @(posedge mclk);
    context_memory_select <= 1'h1;
    quad_word_address <= qa;
    long_word_enable <= 4'h1 << ln;
    mp_rd <= 1'h1;
    @(posedge mclk);
    mp_rd <= 1'h0;
    quad_word_address <= ~qa;
    #1;
    v = mp_rvalid;
    d = 34'(mp_rdata >> (34 * ln));
  endtask
endmodule

// [verif/test_pcc_port_context.sv]
// self-checking bench for the per-port congestion context block
module test_pcc_port_context;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = $clog2(8 + 2);

  // ---------------------------------------------------------------
  // signals, rows and instances
  // ---------------------------------------------------------------
  logic mclk, rst_n, context_memory_select, mp_wr, mp_rd, mp_rvalid;
  logic [10:0] quad_word_address;
  logic [3:0] long_word_enable;
  logic [135:0] mp_wdata, mp_rdata;
  logic arr_valid, arr_low_priority, arr_min_met, arr_frame_continuous_queueing, arr_packet_mode;
  logic arr_first_cell, arr_reasm_active, arr_accept, arr_drop, arr_congestion_drop, rx_error_irq;
  logic dropped_cell_total_inc, priority_drop_total_inc, deq_valid, td_valid, td_is_class;
  logic tx_valid, tx_shaped, tx_grant, tx_answer;
  logic [PW-1:0] arr_port, deq_port, td_port, tx_port;
  logic [15:0] arr_circuit, rx_error_circuit_id;
  logic [12:0] arr_reasm_len, tx_circuit_cells;
  logic [13:0] priority_drop_amount;
  logic [17:0] td_cells;
  logic [1:0] tx_class;
  logic [9:0] port_active;
  int fail_count, comparisons, cycles;

  typedef struct packed {logic sel; logic [10:0] qa; logic [1:0] ln; logic [33:0] wd; logic [33:0] ex;} pcc_rrow_t;
  // inf = low, min_met, fcq, packet, first, reasm; exf = accept, drop, congestion, discard, priority, irq
  typedef struct packed {logic [3:0] port; logic [5:0] inf; logic [12:0] len; logic [5:0] exf;
    logic [13:0] amt;} pcc_arow_t;

  pcc_rrow_t rtab [10] = '{
    '{1'h1, 11'h200, 2'h1, 34'h3FFFF1811, 34'h000001811},
    '{1'h1, 11'h201, 2'h3, 34'h00000A5C3, 34'h00000A5C3},
    '{1'h1, 11'h613, 2'h1, 34'h000005678, 34'h000005678},
    '{1'h1, 11'h400, 2'h2, 34'h3FFFFFFFF, 34'h08FF3FFFF},
    '{1'h1, 11'h400, 2'h1, 34'h082000000, 34'h082000000},
    '{1'h1, 11'h612, 2'h0, 34'h080100000, 34'h080100000},
    '{1'h1, 11'h613, 2'h2, 34'h080000005, 34'h080000005},
    '{1'h1, 11'h613, 2'h0, 34'h00000FFFF, 34'h000000000},
    '{1'h1, 11'h7D0, 2'h0, 34'h00000FFFF, 34'h000000000},
    '{1'h0, 11'h401, 2'h0, 34'h080000000, 34'h000000000}};

  // port 1: low ceiling expands to 2, high to 3, port ceiling to 4; port 3 stays inactive
  pcc_arow_t atab [12] = '{
    '{4'h1, 6'h20, 13'h0, 6'h20, 14'h0},
    '{4'h1, 6'h20, 13'h0, 6'h20, 14'h0},
    '{4'h1, 6'h20, 13'h0, 6'h18, 14'h0},
    '{4'h1, 6'h00, 13'h0, 6'h20, 14'h0},
    '{4'h1, 6'h10, 13'h0, 6'h18, 14'h0},
    '{4'h1, 6'h00, 13'h0, 6'h20, 14'h0},
    '{4'h1, 6'h00, 13'h0, 6'h18, 14'h0},
    '{4'h3, 6'h00, 13'h0, 6'h15, 14'h0},
    '{4'h3, 6'h06, 13'h0, 6'h15, 14'h0},
    '{4'h3, 6'h04, 13'h0, 6'h13, 14'h1},
    '{4'h3, 6'h08, 13'h0, 6'h13, 14'h1},
    '{4'h3, 6'h09, 13'h7, 6'h13, 14'h8}};

  pcc_host_model u_host (.mclk, .context_memory_select, .quad_word_address, .long_word_enable, .mp_wr,
    .mp_rd, .mp_wdata, .mp_rdata, .mp_rvalid);

  pcc_port_context #(.NUM_LOOP(8), .NUM_CLASS(4)) u_dut (.mclk, .rst_n, .context_memory_select,
    .quad_word_address, .long_word_enable, .mp_wr, .mp_rd, .mp_wdata, .mp_rdata, .mp_rvalid, .arr_valid,
    .arr_port, .arr_circuit, .arr_low_priority, .arr_min_met, .arr_frame_continuous_queueing,
    .arr_packet_mode, .arr_first_cell, .arr_reasm_active, .arr_reasm_len, .arr_accept, .arr_drop,
    .arr_congestion_drop, .dropped_cell_total_inc, .priority_drop_total_inc, .priority_drop_amount,
    .rx_error_irq, .rx_error_circuit_id, .deq_valid, .deq_port, .td_valid, .td_is_class, .td_port,
    .td_cells, .tx_valid, .tx_port, .tx_class, .tx_shaped, .tx_circuit_cells, .tx_grant, .tx_answer,
    .port_active);

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // read one lane and compare, answer must come one cycle after the strobe
  task automatic rc(input logic [10:0] qa, input logic [1:0] ln, input logic [33:0] exp);
    logic [33:0] d;
    logic v;
    u_host.rd(qa, ln, d, v);
    chk(v, 34'h1);
    chk(d, exp);
  endtask

  task automatic arr(input pcc_arow_t r, input logic [15:0] cid);
    @(posedge mclk);
    arr_valid <= 1'h1;
    arr_port <= r.port;
    arr_circuit <= cid;
    {arr_low_priority, arr_min_met, arr_frame_continuous_queueing, arr_packet_mode, arr_first_cell,
      arr_reasm_active} <= r.inf;
    arr_reasm_len <= r.len;
    @(posedge mclk);
    arr_valid <= 1'h0;
    #1;
  endtask

  // one-cycle dequeue or teardown pulse on port 1
  task automatic upd(input logic d, input logic t, input logic c, input logic [17:0] n);
    @(posedge mclk);
    {deq_valid, td_valid, td_is_class, td_cells, deq_port, td_port} <= {d, t, c, n, 4'h1, 4'h1};
    @(posedge mclk);
    {deq_valid, td_valid} <= 2'h0;
  endtask

  task automatic tx(input logic [1:0] cls, input logic shp, input logic [12:0] n, input logic g);
    @(posedge mclk);
    {tx_valid, tx_port, tx_class, tx_shaped, tx_circuit_cells} <= {1'h1, 4'h1, cls, shp, n};
    @(posedge mclk);
    tx_valid <= 1'h0;
    #1;
    chk({tx_answer, tx_grant}, {1'h1, g});
  endtask

  // free clock; a hung handshake ends the run as a mismatch
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 2000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'h0;
    {arr_valid, arr_port, arr_circuit, arr_low_priority, arr_min_met, arr_frame_continuous_queueing,
      arr_packet_mode, arr_first_cell, arr_reasm_active, arr_reasm_len, deq_valid, deq_port, td_valid,
      td_is_class, td_port, td_cells, tx_valid, tx_port, tx_class, tx_shaped, tx_circuit_cells} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    chk(port_active, 34'h0);
    rc(11'h400, 2'h0, 34'h0);
    rc(11'h200, 2'h3, 34'h0);
    $display("reset values done");
    foreach (rtab[i]) begin
      u_host.wr(rtab[i].qa, rtab[i].ln, rtab[i].sel, rtab[i].wd);
      rc(rtab[i].qa, rtab[i].ln, rtab[i].ex);
    end
    chk(port_active, 34'h306);
    $display("record map done");
    foreach (atab[i]) begin
      arr(atab[i], 16'h0100 + 16'(i));
      chk({arr_accept, arr_drop, arr_congestion_drop, rx_error_irq}, {atab[i].exf[5:3], atab[i].exf[0]});
      if (atab[i].exf[0] === 1'h1) begin
        chk({dropped_cell_total_inc, priority_drop_total_inc, priority_drop_amount},
          {atab[i].exf[2:1], atab[i].amt});
        chk(rx_error_circuit_id, 16'h0100 + 16'(i));
      end
    end
    rc(11'h400, 2'h1, 34'h082000004);
    $display("arrivals done");
    upd(1'h1, 1'h0, 1'h0, 18'h0);
    upd(1'h0, 1'h1, 1'h0, 18'h2);
    rc(11'h400, 2'h1, 34'h082000001);
    upd(1'h0, 1'h1, 1'h1, 18'h5);
    rc(11'h400, 2'h1, 34'h082000000);
    $display("teardown done");
    tx(2'h0, 1'h0, 13'h3, 1'h1);
    u_host.wr(11'h400, 2'h1, 1'h1, 34'h002000000);
    tx(2'h0, 1'h0, 13'h3, 1'h1);
    tx(2'h0, 1'h0, 13'h3, 1'h0);
    tx(2'h1, 1'h0, 13'h3, 1'h1);
    tx(2'h2, 1'h1, 13'h2, 1'h1);
    tx(2'h2, 1'h1, 13'h1, 1'h0);
    chk(port_active, 34'h304);
    $display("disable done");
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    chk(port_active, 34'h0);
    rc(11'h613, 2'h1, 34'h0);
    $display("second reset done");
    wrap_up();
  end
endmodule
